// [core/lpd_core.sv]
// Pen-sensor detection control: mode latches, address walk-back, status, branch.
`timescale 1ns/10ps
`default_nettype none
module lpd_core
  import lpd_pkg::*;
#(
  parameter int unsigned AW = 16,
  parameter int unsigned CW = 10
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic [BUS_AW-1:0] bus_addr_i,
  input  wire logic [BUS_DW-1:0] bus_wdata_i,
  input  wire logic              bus_we_i,
  input  wire logic              bus_re_i,
  output logic      [BUS_DW-1:0] bus_rdata_o,
  input  wire logic              order_valid_i,
  input  wire lpd_order_t        order_code_i,
  input  wire logic [AW-1:0]     order_addr_i,
  input  wire logic              pen_sensor_i,
  input  wire logic              tip_switch_i,
  input  wire logic              third_timing_pulse_i,
  input  wire logic              relative_mode_i,
  input  wire logic              item_second_byte_i,
  input  wire logic [1:0]        item_byte_pos_i,
  input  wire logic [AW-1:0]     seq_addr_i,
  input  wire logic [CW-1:0]     x_defl_i,
  input  wire logic [CW-1:0]     y_defl_i,
  input  wire logic              set_buffer_address_i,
  input  wire logic              status_taken_i,
  output logic                   branch_o,
  output logic      [AW-1:0]     branch_addr_o,
  output logic                   noop_o,
  output logic                   stop_regen_o,
  output logic                   addr_step_o,
  output logic      [AW-1:0]     buffer_address_counter_o,
  output logic                   attention_o,
  output logic                   busy_o,
  output logic                   unit_check_o,
  output logic                   irq_o
);

  // Whole state of the block
  typedef struct packed {
    lpd_fsm_t              st;
    logic                  pen_s1;
    logic                  pen_s2;
    logic                  tip_s1;
    logic                  tip_s2;
    logic                  cont;
    logic                  normal;
    logic                  dis;
    logic                  nodet;
    logic                  detected;
    logic                  armed;
    logic                  reopen;
    logic [BYTE_CNT_W-1:0] byte_cnt;
    logic [AW-1:0]         item_addr;
    logic [CW-1:0]         x;
    logic [CW-1:0]         y;
    logic                  halt;
    logic                  attn;
    logic                  busy;
    logic                  uchk;
    logic                  branch;
    logic                  noop;
    logic                  step;
    logic                  irq;
    logic [AW-1:0]         br_addr;
    logic [STAT_W-1:0]     status;
    logic [STAT_W-1:0]     mask;
    logic [BUS_DW-1:0]     rdata;
  } lpd_regs_t;

  // All latches clear, detection inactive
  localparam lpd_regs_t REGS_RESET = '0;

  lpd_regs_t         st_reg;
  lpd_regs_t         st_next;
  logic              det_w;
  logic              gate_w;
  logic              sba_abort_w;
  logic              resume_w;
  logic [STAT_W-1:0] ev_w;

  // Zero-extend a field into a bus word
  function automatic logic [BUS_DW-1:0] lpd_word(input logic [BUS_DW-1:0] v);
    lpd_word = v;
  endfunction : lpd_word

  // Next-state logic
  always_comb begin
    st_next        = st_reg;
    st_next.branch = 1'b0;
    st_next.noop   = 1'b0;
    st_next.step   = 1'b0;
    ev_w           = '0;

    // Two-stage synchronisers for the pen pins
    st_next.pen_s1 = pen_sensor_i;
    st_next.pen_s2 = st_reg.pen_s1;
    st_next.tip_s1 = tip_switch_i;
    st_next.tip_s2 = st_reg.tip_s1;

    // Transfer gating: a mode active and no detection yet
    gate_w = !st_reg.detected &&
             (st_reg.normal || (st_reg.cont && st_reg.nodet));

    // Detection acceptance
    det_w = !st_reg.dis && (st_reg.st == LPD_IDLE) && !st_reg.halt &&
            st_reg.pen_s2 &&
            (st_reg.cont ||
             (st_reg.normal && st_reg.armed && st_reg.tip_s2));

    sba_abort_w = set_buffer_address_i &&
                  ((st_reg.st == LPD_WAIT_PULSE3) || (st_reg.st == LPD_ADJUST));
    resume_w    = bus_we_i && (bus_addr_i == REG_CTRL) && bus_wdata_i[CTRL_RESUME];

    // Tip switch must reopen between detections in normal mode
    if (st_reg.reopen && !st_reg.tip_s2) begin
      st_next.reopen = 1'b0;
    end

    // Orders from the buffer program
    if (order_valid_i) begin
      case (order_code_i)
        LPD_ORD_SWITCH_EN: begin
          st_next.normal   = 1'b1;
          st_next.cont     = 1'b0;
          st_next.dis      = 1'b0;
          st_next.detected = 1'b0;
          st_next.armed    = 1'b0;
        end
        LPD_ORD_NOSWITCH_EN: begin
          st_next.cont     = 1'b1;
          st_next.normal   = 1'b0;
          st_next.dis      = 1'b0;
          st_next.nodet    = 1'b1;
          st_next.detected = 1'b0;
        end
        LPD_ORD_DISABLE: begin
          st_next.dis    = 1'b1;
          st_next.cont   = 1'b0;
          st_next.normal = 1'b0;
        end
        LPD_ORD_REGEN_TIMER: begin
          st_next.dis = 1'b0;
          if (st_reg.normal && st_reg.tip_s2 && !st_reg.reopen) begin
            st_next.armed = 1'b1;
          end
        end
        LPD_ORD_XFER_NO_DET: begin
          if (gate_w) begin
            st_next.branch  = 1'b1;
            st_next.br_addr = order_addr_i;
            ev_w[STAT_BRANCH] = 1'b1;
          end else begin
            st_next.noop = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Detection: capture beam and address, stop regeneration
    if (det_w) begin
      st_next.detected = 1'b1;
      st_next.nodet    = 1'b0;
      st_next.item_addr = seq_addr_i;
      st_next.x        = x_defl_i;
      st_next.y        = y_defl_i;
      st_next.halt     = 1'b1;
      st_next.st       = LPD_WAIT_PULSE3;
      if (!st_reg.cont) begin
        st_next.armed  = 1'b0;
        st_next.reopen = 1'b1;
      end
    end

    // Channel takes the ending status
    if (status_taken_i) begin
      st_next.attn = 1'b0;
      st_next.busy = 1'b0;
      st_next.uchk = 1'b0;
    end

    // Detection sequence
    case (st_reg.st)
      LPD_WAIT_PULSE3: begin
        if (third_timing_pulse_i) begin
          if (relative_mode_i) begin
            st_next.byte_cnt = item_second_byte_i ? BYTE_PRESET_SECOND
                                                  : BYTE_PRESET_FIRST;
          end else begin
            st_next.byte_cnt = BYTE_ABS_BASE +
                               {{(BYTE_CNT_W-2){1'b0}}, item_byte_pos_i};
          end
          st_next.st = LPD_ADJUST;
        end
      end
      LPD_ADJUST: begin
        if (st_reg.byte_cnt == BYTE_CNT_LAST) begin
          st_next.st = LPD_DONE;
        end else begin
          st_next.byte_cnt = st_reg.byte_cnt + {{(BYTE_CNT_W-1){1'b0}}, 1'b1};
          st_next.item_addr = st_reg.item_addr - {{(AW-1){1'b0}}, 1'b1};
          st_next.step     = 1'b1;
        end
      end
      LPD_DONE: begin
        st_next.attn = 1'b1;
        st_next.busy = 1'b1;
        st_next.uchk = 1'b1;
        ev_w[STAT_DETECT] = 1'b1;
        st_next.st = LPD_IDLE;
      end
      default: begin
      end
    endcase

    // Channel command has priority over a pending detection
    if (sba_abort_w) begin
      st_next.st   = LPD_IDLE;
      st_next.halt = 1'b0;
      st_next.step = 1'b0;
      ev_w[STAT_ABORT] = 1'b1;
    end

    // Software resumes regeneration once the sequence has ended
    if (resume_w && (st_reg.st == LPD_IDLE) && !det_w) begin
      st_next.halt = 1'b0;
    end

    // Register writes; sticky status keeps new events over a clear
    if (bus_we_i) begin
      if (bus_addr_i == REG_MASK) begin
        st_next.mask = bus_wdata_i[STAT_W-1:0];
      end
    end
    if (bus_we_i && (bus_addr_i == REG_STATUS)) begin
      st_next.status = (st_reg.status & ~bus_wdata_i[STAT_W-1:0]) | ev_w;
    end else begin
      st_next.status = st_reg.status | ev_w;
    end
    st_next.irq = |(st_next.status & st_next.mask);

    // Register reads, data valid the next cycle
    st_next.rdata = '0;
    if (bus_re_i) begin
      if (bus_addr_i == REG_STATUS) begin
        st_next.rdata = lpd_word({{(BUS_DW-STAT_W){1'b0}}, st_reg.status});
      end else if (bus_addr_i == REG_MASK) begin
        st_next.rdata = lpd_word({{(BUS_DW-STAT_W){1'b0}}, st_reg.mask});
      end else if (bus_addr_i == REG_MODE) begin
        st_next.rdata[MODE_CONT]   = st_reg.cont;
        st_next.rdata[MODE_NORMAL] = st_reg.normal;
        st_next.rdata[MODE_DIS]    = st_reg.dis;
        st_next.rdata[MODE_NODET]  = st_reg.nodet;
        st_next.rdata[MODE_DET]    = st_reg.detected;
        st_next.rdata[MODE_HALT]   = st_reg.halt;
        st_next.rdata[MODE_ARMED]  = st_reg.armed;
        st_next.rdata[MODE_REOPEN] = st_reg.reopen;
      end else if (bus_addr_i == REG_XY) begin
        st_next.rdata[CW-1:0]                 = st_reg.x;
        st_next.rdata[XY_Y_LSB+CW-1:XY_Y_LSB] = st_reg.y;
      end else if (bus_addr_i == REG_ADDR) begin
        st_next.rdata = lpd_word({{(BUS_DW-AW){1'b0}}, st_reg.item_addr});
      end else begin
        st_next.rdata = '0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= REGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs, all from the state register
  assign bus_rdata_o              = st_reg.rdata;
  assign branch_o                 = st_reg.branch;
  assign branch_addr_o            = st_reg.br_addr;
  assign noop_o                   = st_reg.noop;
  assign stop_regen_o             = st_reg.halt;
  assign addr_step_o              = st_reg.step;
  assign buffer_address_counter_o = st_reg.item_addr;
  assign attention_o              = st_reg.attn;
  assign busy_o                   = st_reg.busy;
  assign unit_check_o             = st_reg.uchk;
  assign irq_o                    = st_reg.irq;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_cont_detect;
    st_reg.cont && !st_reg.dis && (st_reg.st == LPD_IDLE) && !st_reg.halt &&
    st_reg.pen_s2 |=> (st_reg.st == LPD_WAIT_PULSE3) && st_reg.halt;
  endproperty
  a_cont_detect: assert property (p_cont_detect) else $error("continuous detect missed");

  property p_noswitch_nodet;
    order_valid_i && (order_code_i == LPD_ORD_NOSWITCH_EN) && !det_w |=> st_reg.nodet;
  endproperty
  a_noswitch_nodet: assert property (p_noswitch_nodet) else $error("no-detect not set");

  property p_det_clears_nodet;
    det_w |=> !st_reg.nodet && st_reg.detected;
  endproperty
  a_det_clears_nodet: assert property (p_det_clears_nodet) else $error("no-detect kept");

  property p_preset;
    (st_reg.st == LPD_WAIT_PULSE3) && third_timing_pulse_i && relative_mode_i &&
    !sba_abort_w |=> st_reg.byte_cnt ==
    ($past(item_second_byte_i) ? BYTE_PRESET_SECOND : BYTE_PRESET_FIRST);
  endproperty
  a_preset: assert property (p_preset) else $error("byte counter preset wrong");

  property p_walk_back;
    (st_reg.st == LPD_ADJUST) && (st_reg.byte_cnt != BYTE_CNT_LAST) && !sba_abort_w
    |=> st_reg.step && (st_reg.item_addr == $past(st_reg.item_addr) - {{(AW-1){1'b0}}, 1'b1});
  endproperty
  a_walk_back: assert property (p_walk_back) else $error("address not stepped back");

  property p_end_status;
    (st_reg.st == LPD_DONE) && !sba_abort_w |=> st_reg.attn && st_reg.busy &&
    st_reg.uchk && st_reg.status[STAT_DETECT] && (irq_o || !st_reg.mask[STAT_DETECT]);
  endproperty
  a_end_status: assert property (p_end_status) else $error("ending status missing");

  property p_halt_holds;
    st_reg.halt && !resume_w && !set_buffer_address_i |=> st_reg.halt && $stable(st_reg.x);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt dropped");

  property p_sba_abort;
    sba_abort_w |=> (st_reg.st == LPD_IDLE) && !stop_regen_o && st_reg.status[STAT_ABORT];
  endproperty
  a_sba_abort: assert property (p_sba_abort) else $error("abort ignored");

  property p_dis_blocks;
    st_reg.dis |-> !det_w;
  endproperty
  a_dis_blocks: assert property (p_dis_blocks) else $error("detect while disabled");

  property p_dis_latches;
    order_valid_i && (order_code_i == LPD_ORD_DISABLE) |=>
    st_reg.dis && !st_reg.cont && !st_reg.normal;
  endproperty
  a_dis_latches: assert property (p_dis_latches) else $error("disable latches wrong");

  property p_dis_runs;
    st_reg.dis && !st_reg.halt |=> !stop_regen_o;
  endproperty
  a_dis_runs: assert property (p_dis_runs) else $error("regeneration stopped");

  property p_dis_release;
    order_valid_i && ((order_code_i == LPD_ORD_REGEN_TIMER) ||
    (order_code_i == LPD_ORD_SWITCH_EN) || (order_code_i == LPD_ORD_NOSWITCH_EN))
    |=> !st_reg.dis;
  endproperty
  a_dis_release: assert property (p_dis_release) else $error("disable not released");

  property p_branch;
    order_valid_i && (order_code_i == LPD_ORD_XFER_NO_DET) && gate_w |=>
    branch_o && !noop_o && (branch_addr_o == $past(order_addr_i));
  endproperty
  a_branch: assert property (p_branch) else $error("branch missing");

  property p_noop;
    order_valid_i && (order_code_i == LPD_ORD_XFER_NO_DET) && !gate_w |=>
    noop_o && !branch_o;
  endproperty
  a_noop: assert property (p_noop) else $error("no-op missing");

  property p_switch_mode;
    order_valid_i && (order_code_i == LPD_ORD_SWITCH_EN) |=> !st_reg.cont && st_reg.normal;
  endproperty
  a_switch_mode: assert property (p_switch_mode) else $error("switch mode wrong");

  property p_noswitch_mode;
    order_valid_i && (order_code_i == LPD_ORD_NOSWITCH_EN) |=> st_reg.cont;
  endproperty
  a_noswitch_mode: assert property (p_noswitch_mode) else $error("continuous not set");

  // Main scenarios
  c_detect_done: cover property ((st_reg.st == LPD_DONE) ##1 irq_o);
  c_branch:      cover property (branch_o);
  c_abort:       cover property (sba_abort_w);
  c_noop_after:  cover property (noop_o && st_reg.detected);

endmodule : lpd_core
`default_nettype wire

// [core/lpd_pkg.sv]
// Package for the pen-sensor detection control block: map, fields, orders.
// How it works
// - Continuous mode detects regardless of tip switch.
// - No-switch enable order sets the no-detect latch.
// - A detection clears the no-detect latch.
// - Third timing pulse presets byte counter 4/5 in relative mode, else 2 plus byte position.
// - Step address down per byte-count step up.
// - Detection ends with attention, busy, check, interrupt.
// - Halt regeneration, hold coordinates and item address.
// - Set-buffer-address command aborts a pending detection.
// - Disable order blocks detections until a timer, switch or no-switch order ends it.
// - Disable sets disable latch, clears both modes.
// - Regeneration keeps running while disabled.
// - Timer, switch or no-switch order ends disable.
// - Transfer order without detection branches to operand.
// - Transfer order after a detection is a no-op.
// - Gate transfer only in a mode without detection.
// - Ungated transfer order becomes a no-op.
// - Switch enable: clear continuous, switch-timer-detect sequence.
// - No-switch enable sets continuous, bypassing switch and timer.
package lpd_pkg;

  // Register bus
  localparam int unsigned BUS_AW = 8;
  localparam int unsigned BUS_DW = 32;

  // Register byte addresses
  localparam logic [BUS_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [BUS_AW-1:0] REG_MASK   = 8'h08;
  localparam logic [BUS_AW-1:0] REG_MODE   = 8'h0C;
  localparam logic [BUS_AW-1:0] REG_XY     = 8'h10;
  localparam logic [BUS_AW-1:0] REG_ADDR   = 8'h14;

  // Control register field
  localparam int unsigned CTRL_RESUME = 0;

  // Status and mask register fields
  localparam int unsigned STAT_W      = 3;
  localparam int unsigned STAT_DETECT = 0;
  localparam int unsigned STAT_BRANCH = 1;
  localparam int unsigned STAT_ABORT  = 2;

  // Mode register fields
  localparam int unsigned MODE_CONT   = 0;
  localparam int unsigned MODE_NORMAL = 1;
  localparam int unsigned MODE_DIS    = 2;
  localparam int unsigned MODE_NODET  = 3;
  localparam int unsigned MODE_DET    = 4;
  localparam int unsigned MODE_HALT   = 5;
  localparam int unsigned MODE_ARMED  = 6;
  localparam int unsigned MODE_REOPEN = 7;

  // Coordinate register: Y in the upper half
  localparam int unsigned XY_Y_LSB = 16;

  // Byte counter used to walk the address back to the item
  localparam int unsigned       BYTE_CNT_W   = 3;
  localparam logic [BYTE_CNT_W-1:0] BYTE_PRESET_FIRST  = 3'h4;
  localparam logic [BYTE_CNT_W-1:0] BYTE_PRESET_SECOND = 3'h5;
  localparam logic [BYTE_CNT_W-1:0] BYTE_ABS_BASE      = 3'h2;
  localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_LAST      = 3'h6;

  // Orders decoded by the buffer sequencer
  typedef enum logic [2:0] {
    LPD_ORD_NONE,
    LPD_ORD_SWITCH_EN,
    LPD_ORD_NOSWITCH_EN,
    LPD_ORD_DISABLE,
    LPD_ORD_XFER_NO_DET,
    LPD_ORD_REGEN_TIMER
  } lpd_order_t;

  // Detection sequence
  typedef enum logic [1:0] {
    LPD_IDLE,
    LPD_WAIT_PULSE3,
    LPD_ADJUST,
    LPD_DONE
  } lpd_fsm_t;

endpackage : lpd_pkg

// [test/lpd_seq_model.sv]
// Sequencer model: timing pulses and buffer address stepping.
`timescale 1ns/10ps
`default_nettype none
module lpd_seq_model #(
  parameter int unsigned AW = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          load_i,
  input  wire logic [AW-1:0] load_addr_i,
  input  wire logic          addr_step_i,
  input  wire logic          branch_i,
  input  wire logic [AW-1:0] branch_addr_i,
  output logic               pulse3_o,
  output logic      [AW-1:0] addr_o
);
  logic [2:0] phase;

  // Third pulse once in every eight cycles, free running
  assign pulse3_o = (phase == 3'h7);

  // Address: loaded, branched, or stepped back by the block
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= 3'h0;
      addr_o <= '0;
    end else begin
      phase <= phase + 3'h1;
      if (load_i) begin
        addr_o <= load_addr_i;
      end else if (branch_i) begin
        addr_o <= branch_addr_i;
      end else if (addr_step_i) begin
        addr_o <= addr_o - 1'b1;
      end
    end
  end
endmodule : lpd_seq_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the pen-sensor detection control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lpd_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        ov = 1'b0;
  lpd_order_t  oc = LPD_ORD_NONE;
  logic [15:0] oa = 16'h0;
  logic        pen = 1'b0;
  logic        tip = 1'b0;
  logic        rel = 1'b0;
  logic        sec = 1'b0;
  logic [1:0]  pos = 2'h0;
  logic [9:0]  xv = 10'h0;
  logic [9:0]  yv = 10'h0;
  logic        sba = 1'b0;
  logic        taken = 1'b0;
  logic        load = 1'b0;
  logic [15:0] base = 16'h0;
  logic        pulse3, br, noop, stop, step, attn, busy, uchk, irq;
  logic [15:0] seq_addr, br_addr, item_addr, a;
  logic [31:0] rdata, rd_val;
  logic [15:0] br_q [$];
  lpd_order_t  clr [3] = '{LPD_ORD_REGEN_TIMER, LPD_ORD_SWITCH_EN, LPD_ORD_NOSWITCH_EN};
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 46261;

  // Clock and cycle ceiling
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      end_of_test();
    end
  end

  lpd_seq_model u_seq (.ref_clk_i(clk), .nrst_i(nrst), .load_i(load), .load_addr_i(base),
    .addr_step_i(step), .branch_i(br), .branch_addr_i(br_addr), .pulse3_o(pulse3),
    .addr_o(seq_addr));

  lpd_core uut (.ref_clk_i(clk), .nrst_i(nrst), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_we_i(we), .bus_re_i(re), .bus_rdata_o(rdata), .order_valid_i(ov),
    .order_code_i(oc), .order_addr_i(oa), .pen_sensor_i(pen), .tip_switch_i(tip),
    .third_timing_pulse_i(pulse3), .relative_mode_i(rel), .item_second_byte_i(sec),
    .item_byte_pos_i(pos), .seq_addr_i(seq_addr), .x_defl_i(xv), .y_defl_i(yv),
    .set_buffer_address_i(sba), .status_taken_i(taken), .branch_o(br),
    .branch_addr_o(br_addr), .noop_o(noop), .stop_regen_o(stop), .addr_step_o(step),
    .buffer_address_counter_o(item_addr), .attention_o(attn), .busy_o(busy),
    .unit_check_o(uchk), .irq_o(irq));

  // Branch model: each branch pulse takes the oldest predicted target
  always @(negedge clk) begin
    if (br === 1'b1) begin
      chk("brpending", 32'h1, {31'h0, br_q.size() != 0});
      if (br_q.size() != 0) begin
        chk("brqueue", {16'h0, br_q.pop_front()}, {16'h0, br_addr});
      end
    end
  end

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    addr <= ad;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask : rd

  task automatic ord(input lpd_order_t c, input logic [15:0] ad);
    @(posedge clk);
    oc <= c;
    oa <= ad;
    ov <= 1'b1;
    @(posedge clk);
    ov <= 1'b0;
    @(negedge clk);
  endtask : ord

  // Full detection, walk-back and release, checked against the count model
  task automatic detect(input logic r, input logic s, input logic [1:0] p);
    int steps;
    int pre;
    logic [15:0] b;
    steps = 0;
    pre = r ? (s ? 5 : 4) : 2 + p;
    b = 16'($random(seed));
    @(posedge clk);
    rel <= r;
    sec <= s;
    pos <= p;
    base <= b;
    load <= 1'b1;
    xv <= 10'($random(seed));
    yv <= 10'($random(seed));
    pen <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    for (int i = 0; i < 60 && attn !== 1'b1; i++) begin
      @(negedge clk);
      if (step === 1'b1) steps++;
    end
    @(posedge clk);
    pen <= 1'b0;
    chk("steps", 32'(6 - pre), 32'(steps));
    chk("addr", {16'h0, b - 16'(6 - pre)}, {16'h0, item_addr});
    chk("seq", {16'h0, item_addr}, {16'h0, seq_addr});
    chk("ending", 32'h7, {29'h0, attn, busy, uchk});
    tick(2);
    chk("irq", 32'h1, {31'h0, irq});
    chk("stop", 32'h1, {31'h0, stop});
    rd(REG_XY);
    chk("xy", {6'h0, yv, 6'h0, xv}, rd_val);
    rd(REG_ADDR);
    chk("regaddr", {16'h0, b - 16'(6 - pre)}, rd_val);
    rd(REG_MODE);
    chk("nodet", 32'h10, rd_val & 32'h18);
    ord(LPD_ORD_XFER_NO_DET, 16'h1234);
    chk("noop", 32'h1, {30'h0, br, noop});
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    wr(REG_STATUS, 32'h7);
    wr(REG_CTRL, 32'h1);
    tick(2);
    chk("released", 32'h0, {28'h0, attn, busy, uchk, stop});
  endtask : detect

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_MODE);
    chk("mode", 32'h0, rd_val);
    rd(8'h20);
    chk("unmapped", 32'h0, rd_val);
    wr(REG_MASK, 32'h7);
    ord(LPD_ORD_XFER_NO_DET, 16'h0042);
    chk("nomode", 32'h1, {30'h0, br, noop});
    ord(LPD_ORD_SWITCH_EN, 16'h0);
    rd(REG_MODE);
    chk("switch", 32'h2, rd_val & 32'h7);
    a = 16'($random(seed));
    br_q.push_back(a);
    ord(LPD_ORD_XFER_NO_DET, a);
    chk("branch", {15'h0, 1'b1, a}, {15'h0, br, br_addr});
    tick(2);
    chk("target", {16'h0, a}, {16'h0, seq_addr});
    chk("irq", 32'h1, {31'h0, irq});
    wr(REG_MASK, 32'h0);
    tick(2);
    chk("masked", 32'h0, {31'h0, irq});
    wr(REG_MASK, 32'h7);
    wr(REG_STATUS, 32'h7);
    tick(2);
    chk("cleared", 32'h0, {31'h0, irq});
    // Switch mode: open tip refuses, then tip closed plus timer order
    @(posedge clk);
    pen <= 1'b1;
    tick(10);
    chk("tipopen", 32'h0, {31'h0, stop});
    @(posedge clk);
    pen <= 1'b0;
    tip <= 1'b1;
    tick(4);
    ord(LPD_ORD_REGEN_TIMER, 16'h0);
    detect(1'b1, 1'b0, 2'h0);
    @(posedge clk);
    tip <= 1'b0;
    // Disable mode and each order that ends it
    for (int k = 0; k < 3; k++) begin
      ord(LPD_ORD_DISABLE, 16'h0);
      rd(REG_MODE);
      chk("disable", 32'h4, rd_val & 32'h7);
      if (k == 0) begin
        @(posedge clk);
        pen <= 1'b1;
        tick(12);
        chk("blocked", 32'h0, {31'h0, stop});
        @(posedge clk);
        pen <= 1'b0;
        ord(LPD_ORD_XFER_NO_DET, 16'h0077);
        chk("disnoop", 32'h1, {30'h0, br, noop});
      end
      ord(clr[k], 16'h0);
      rd(REG_MODE);
      chk("undisable", 32'h0, rd_val & 32'h4);
    end
    rd(REG_MODE);
    chk("cont", 32'h9, rd_val & 32'h9);
    a = 16'($random(seed));
    br_q.push_back(a);
    ord(LPD_ORD_XFER_NO_DET, a);
    chk("contbr", {15'h0, 1'b1, a}, {15'h0, br, br_addr});
    wr(REG_STATUS, 32'h7);
    // Back-to-back detections with tip open, every preset path
    for (int i = 0; i < 4; i++) begin
      detect(i < 2, i[0], i == 2 ? 2'h0 : 2'($random(seed)));
    end
    // Channel command aborts a pending detection
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    pen <= 1'b0;
    for (int i = 0; i < 20 && stop !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    sba <= 1'b1;
    @(posedge clk);
    sba <= 1'b0;
    tick(3);
    chk("abort", 32'h0, {30'h0, stop, attn});
    rd(REG_STATUS);
    chk("abortst", 32'h4, rd_val & 32'h5);
    chk("brleft", 32'h0, 32'(br_q.size()));
    end_of_test();
  end
endmodule : tb
`default_nettype wire
